// ==== src/smx_top.sv ====
// SMBus extension of a two-wire controller: reserved addresses, packet check, SCL timeouts.
// Assumes an APB master on pclk and a byte-level bus core on pclk; scl_in is an async pin.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "smx_consts.svh"

module smx_top #(
	parameter int LIMIT_W = 12
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	// Bus pin
	input  wire logic        scl_in,
	// Bus core side
	input  wire logic        xfer_start,
	input  wire logic        xfer_is_slave,
	input  wire logic        addr_valid,
	input  wire logic [7:0]  addr_byte,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output logic             core_enable,
	output logic             addr_ack,
	output logic             check_byte_due,
	output logic      [7:0]  check_value,
	output logic             end_stop,
	output logic             end_reload
);
	if (LIMIT_W != 12)
	begin : g_bad_width
		$error("smx_top: LIMIT_W must be 12");
	end

	// ------------------------------------------------------------
	// Address decode helpers
	// ------------------------------------------------------------
	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a == `SMX_OFS_CTRL1) || (a == `SMX_OFS_CTRL2) ||
			(a == `SMX_OFS_WATCH) || (a == `SMX_OFS_STATUS) ||
			(a == `SMX_OFS_MASK) || (a == `SMX_OFS_CHECK);
	endfunction

	function automatic logic special_match(input logic [6:0] a, input smx_pkg::smx_ctrl1_s c);
		special_match = (c.default_dev_addr_enable && a == `SMX_ADDR_DEV_DEFAULT) ||
			(c.host_addr_enable && a == `SMX_ADDR_HOST) ||
			(c.alarm_response_enable && a == `SMX_ADDR_ALARM);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	smx_pkg::smx_ctrl1_s ctrl1, next_ctrl1;
	smx_pkg::smx_ctrl2_s ctrl2, next_ctrl2;
	smx_pkg::smx_watch_s watch, next_watch;
	smx_pkg::smx_evt_s   status, next_status, mask, next_mask, evt;
	smx_pkg::smx_state_e state, next_state;
	logic [7:0]          remaining, next_remaining;
	logic [7:0]          crc, next_crc, crc_step_in, crc_step_out, crc_step_data;
	logic                slave_mode, next_slave_mode;
	logic [31:0]         next_prdata;
	logic                next_pready, next_pslverr, next_irq;
	logic                next_addr_ack, next_due, next_end_stop, next_end_reload;
	logic                scl_meta, scl_sync;
	logic                wr_en, rd_setup, armed, scl_low, watch_on;
	logic [1:0]          timer_fire;

	// ------------------------------------------------------------
	// SCL synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
		end
		else
		begin
			scl_meta <= scl_in;
			scl_sync <= scl_meta;
		end
	end

	assign scl_low  = !scl_sync;
	assign watch_on = watch.low_check_enable && watch.ext_low_check_enable;

	// ------------------------------------------------------------
	// Timeout timers: 0 = continuous low, 1 = cumulative low
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++)
	begin : g_timer
		logic [10:0]        pre, next_pre;
		logic [LIMIT_W-1:0] cnt, next_cnt, lim;
		logic               done, next_done, run, clr, tick, next_fire, fire;

		always_comb
		begin
			if (g == 0)
			begin
				lim = watch.scl_low_limit;
				run = watch_on && !watch.idle_select && scl_low;
				clr = !run;
			end
			else
			begin
				lim = watch.cumulative_low_limit;
				run = watch_on && state == smx_pkg::SMX_DATA && scl_low;
				clr = !watch_on || xfer_start;
			end
			tick      = run && pre == `SMX_PRE_MAX;
			next_pre  = pre;
			next_cnt  = cnt;
			next_done = done;
			next_fire = 1'b0;
			if (clr)
			begin
				next_pre  = 11'h000;
				next_cnt  = '0;
				next_done = 1'b0;
			end
			else if (run && !done)
			begin
				next_pre = pre + 11'h001;
				if (tick)
				begin
					if (cnt == lim)
					begin
						next_fire = 1'b1;
						next_done = 1'b1;
					end
					else
					begin
						next_cnt = cnt + 1'b1;
					end
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				pre  <= 11'h000;
				cnt  <= '0;
				done <= 1'b0;
				fire <= 1'b0;
			end
			else
			begin
				pre  <= next_pre;
				cnt  <= next_cnt;
				done <= next_done;
				fire <= next_fire;
			end
		end

		assign timer_fire[g] = fire;
	end

	// ------------------------------------------------------------
	// Byte counter and packet check
	// ------------------------------------------------------------
	smx_crc8 #(
		.POLY (`SMX_CRC_POLY)
	) u_crc (
		.crc_in  (crc_step_in),
		.data    (crc_step_data),
		.crc_out (crc_step_out)
	);

	assign armed = ctrl1.check_enable && ctrl2.send_check_byte && !ctrl2.count_refill &&
		(!slave_mode || ctrl2.slave_byte_count_ctrl);

	always_comb
	begin
		next_state      = state;
		next_remaining  = remaining;
		next_slave_mode = slave_mode;
		next_crc        = crc;
		next_addr_ack   = 1'b0;
		next_end_stop   = 1'b0;
		next_end_reload = 1'b0;
		crc_step_in     = crc;
		crc_step_data   = addr_valid ? addr_byte : byte_data;
		evt             = '0;
		evt.timeout     = timer_fire[0];
		evt.ext_timeout = timer_fire[1];
		if (xfer_start && ctrl1.periph_enable)
		begin
			next_state      = smx_pkg::SMX_DATA;
			next_remaining  = ctrl2.byte_count;
			next_slave_mode = xfer_is_slave;
			next_crc        = `SMX_CRC_SEED;
			crc_step_in     = `SMX_CRC_SEED;
		end
		if (addr_valid && ctrl1.periph_enable)
		begin
			next_crc = crc_step_out;
			if (special_match(addr_byte[7:1], ctrl1))
			begin
				next_addr_ack = 1'b1;
				evt.addr_hit  = 1'b1;
			end
		end
		else if (byte_valid && state == smx_pkg::SMX_DATA && remaining != 8'h00)
		begin
			next_remaining = remaining - 8'h01;
			if (armed && remaining == 8'h01)
			begin
				evt.check_error = byte_data != crc;
			end
			else
			begin
				next_crc = crc_step_out;
			end
			if (remaining == 8'h01)
			begin
				evt.count_done = 1'b1;
				if (ctrl2.count_refill)
				begin
					next_end_reload = 1'b1;
					next_remaining  = ctrl2.byte_count;
				end
				else
				begin
					next_state    = smx_pkg::SMX_IDLE;
					next_end_stop = ctrl2.auto_stop && !slave_mode;
				end
			end
		end
		next_due = next_state == smx_pkg::SMX_DATA && next_remaining == 8'h01 && armed;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state          <= smx_pkg::SMX_IDLE;
			remaining      <= 8'h00;
			slave_mode     <= 1'b0;
			crc            <= `SMX_CRC_SEED;
			addr_ack       <= 1'b0;
			check_byte_due <= 1'b0;
			end_stop       <= 1'b0;
			end_reload     <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			remaining      <= next_remaining;
			slave_mode     <= next_slave_mode;
			crc            <= next_crc;
			addr_ack       <= next_addr_ack;
			check_byte_due <= next_due;
			end_stop       <= next_end_stop;
			end_reload     <= next_end_reload;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			check_value <= `SMX_CRC_SEED;
		else
			check_value <= next_crc;
	end

	// ------------------------------------------------------------
	// APB registers and interrupt
	// ------------------------------------------------------------
	assign wr_en    = psel && penable && pready && pwrite;
	assign rd_setup = psel && penable && !pready;

	always_comb
	begin
		next_ctrl1   = ctrl1;
		next_ctrl2   = ctrl2;
		next_watch   = watch;
		next_mask    = mask;
		next_status  = status;
		next_pready  = psel && penable && !pready;
		next_pslverr = rd_setup && !reg_known(paddr);
		next_prdata  = prdata;
		if (wr_en && paddr == `SMX_OFS_CTRL1)
		begin
			next_ctrl1.periph_enable           = pwdata[0];
			next_ctrl1.default_dev_addr_enable = pwdata[1];
			next_ctrl1.host_addr_enable        = pwdata[2];
			next_ctrl1.alarm_response_enable   = pwdata[3];
			if (!ctrl1.periph_enable)
				next_ctrl1.check_enable = pwdata[4];
		end
		if (wr_en && paddr == `SMX_OFS_CTRL2)
			next_ctrl2 = pwdata[11:0];
		if (wr_en && paddr == `SMX_OFS_WATCH)
		begin
			next_watch.low_check_enable     = pwdata[`SMX_WATCH_LOW_BIT];
			next_watch.ext_low_check_enable = pwdata[`SMX_WATCH_EXT_BIT];
			next_watch.cumulative_low_limit = pwdata[`SMX_WATCH_CUM_LSB +: 12];
			if (!watch.low_check_enable)
			begin
				next_watch.scl_low_limit = pwdata[`SMX_WATCH_LIMIT_LSB +: 12];
				next_watch.idle_select   = pwdata[`SMX_WATCH_IDLE_BIT];
			end
		end
		if (wr_en && paddr == `SMX_OFS_MASK)
			next_mask = pwdata[4:0];
		if (wr_en && paddr == `SMX_OFS_STATUS)
			next_status = status & ~smx_pkg::smx_evt_s'(pwdata[4:0]);
		next_status = next_status | evt;
		next_irq    = |(next_status & next_mask);
		if (rd_setup)
		begin
			case (paddr)
				`SMX_OFS_CTRL1:  next_prdata = {27'h0000000, ctrl1};
				`SMX_OFS_CTRL2:  next_prdata = {20'h00000, ctrl2};
				`SMX_OFS_WATCH:  next_prdata = {watch.ext_low_check_enable, 3'h0,
					watch.cumulative_low_limit, watch.low_check_enable, 2'h0,
					watch.idle_select, watch.scl_low_limit};
				`SMX_OFS_STATUS: next_prdata = {27'h0000000, status};
				`SMX_OFS_MASK:   next_prdata = {27'h0000000, mask};
				`SMX_OFS_CHECK:  next_prdata = {15'h0000, state == smx_pkg::SMX_DATA,
					remaining, crc};
				default:         next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl1       <= `SMX_RST_CTRL1;
			ctrl2       <= `SMX_RST_CTRL2;
			watch       <= '0;
			status      <= `SMX_RST_STATUS;
			mask        <= `SMX_RST_MASK;
			prdata      <= 32'h00000000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			irq         <= 1'b0;
			core_enable <= 1'b0;
		end
		else
		begin
			ctrl1       <= next_ctrl1;
			ctrl2       <= next_ctrl2;
			watch       <= next_watch;
			status      <= next_status;
			mask        <= next_mask;
			prdata      <= next_prdata;
			pready      <= next_pready;
			pslverr     <= next_pslverr;
			irq         <= next_irq;
			core_enable <= next_ctrl1.periph_enable;
		end
	end
endmodule

// ==== pkg/smx_consts.svh ====
// Offsets, field positions, reset values and timing counts of the SMBus extension.
// Included by the design files, the checker and the bench; holds definitions only.
`ifndef SMX_CONSTS_SVH
`define SMX_CONSTS_SVH

// Register byte offsets
`define SMX_OFS_CTRL1      8'h00
`define SMX_OFS_CTRL2      8'h04
`define SMX_OFS_WATCH      8'h08
`define SMX_OFS_STATUS     8'h0C
`define SMX_OFS_MASK       8'h10
`define SMX_OFS_CHECK      8'h14

// Watch register field positions
`define SMX_WATCH_LIMIT_LSB 0
`define SMX_WATCH_IDLE_BIT  12
`define SMX_WATCH_LOW_BIT   15
`define SMX_WATCH_CUM_LSB   16
`define SMX_WATCH_EXT_BIT   31

// Reserved SMBus addresses (7 bit)
`define SMX_ADDR_DEV_DEFAULT 7'h61
`define SMX_ADDR_HOST        7'h08
`define SMX_ADDR_ALARM       7'h0C

// Checksum polynomial x^8+x^2+x+1 and seed
`define SMX_CRC_POLY 8'h07
`define SMX_CRC_SEED 8'h00

// Kernel clock periods per timeout tick
`define SMX_TICK_CYCLES 2048
`define SMX_PRE_MAX     11'h7FF

// Reset values
`define SMX_RST_CTRL1  5'h00
`define SMX_RST_CTRL2  12'h000
`define SMX_RST_STATUS 5'h00
`define SMX_RST_MASK   5'h00

`endif

// ==== pkg/smx_pkg.sv ====
// Types of the SMBus extension block: register images, events and states.
// Field positions and numbers live in smx_consts.svh.
package smx_pkg;

	typedef struct packed {
		logic check_enable;
		logic alarm_response_enable;
		logic host_addr_enable;
		logic default_dev_addr_enable;
		logic periph_enable;
	} smx_ctrl1_s;

	typedef struct packed {
		logic       slave_byte_count_ctrl;
		logic       send_check_byte;
		logic       auto_stop;
		logic       count_refill;
		logic [7:0] byte_count;
	} smx_ctrl2_s;

	typedef struct packed {
		logic        ext_low_check_enable;
		logic [11:0] cumulative_low_limit;
		logic        low_check_enable;
		logic        idle_select;
		logic [11:0] scl_low_limit;
	} smx_watch_s;

	typedef struct packed {
		logic count_done;
		logic check_error;
		logic addr_hit;
		logic ext_timeout;
		logic timeout;
	} smx_evt_s;

	typedef enum logic [1:0] {
		SMX_IDLE,
		SMX_DATA
	} smx_state_e;

endpackage

// ==== src/smx_crc8.sv ====
// One byte step of the SMBus packet checksum.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "smx_consts.svh"
module smx_crc8 #(
	parameter logic [7:0] POLY = `SMX_CRC_POLY
) (
	// Running value and byte
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] data,
	// Updated value
	output logic      [7:0] crc_out
);
	always_comb
	begin
		logic [7:0] acc;
		acc = crc_in ^ data;
		for (int i = 0; i < 8; i++)
		begin
			acc = acc[7] ? ((acc << 1) ^ POLY) : (acc << 1);
		end
		crc_out = acc;
	end
endmodule

// ==== verification/smx_top_sva.sv ====
// Checker for smx_top: address gating, check byte, refill, checksum.
// Sees smx_top ports only; bound below.
`timescale 1ns/1ps
`include "smx_consts.svh"
module smx_top_chk (
	// Clock, reset, APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Core side
	input wire logic        xfer_start,
	input wire logic        addr_valid,
	input wire logic [7:0]  addr_byte,
	input wire logic        byte_valid,
	input wire logic        addr_ack,
	input wire logic        check_byte_due,
	input wire logic [7:0]  check_value,
	input wire logic        end_stop,
	input wire logic        end_reload
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [3:0] c1;
	logic [3:0] next_c1;
	logic       rf;
	logic       next_rf;
	logic       wr;
	logic [6:0] a7;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign a7 = addr_byte[7:1];
	// Mirror of enables and refill
	always_comb
	begin
		next_c1 = c1;
		next_rf = rf;
		if (wr && paddr == `SMX_OFS_CTRL1)
			next_c1 = pwdata[3:0];
		if (wr && paddr == `SMX_OFS_CTRL2)
			next_rf = pwdata[8];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			c1 <= 4'h0;
			rf <= 1'b0;
		end
		else
		begin
			c1 <= next_c1;
			rf <= next_rf;
		end
	end
	dev_gate_a: assert property (addr_valid && a7 == `SMX_ADDR_DEV_DEFAULT && !c1[1]
		|=> !addr_ack) else $error("default address acked while off");
	host_gate_a: assert property (addr_valid && a7 == `SMX_ADDR_HOST && !c1[2]
		|=> !addr_ack) else $error("host address acked while off");
	alarm_gate_a: assert property (addr_valid && a7 == `SMX_ADDR_ALARM && !c1[3]
		|=> !addr_ack) else $error("alert address acked while off");
	ack_cause_a: assert property (addr_ack |-> $past(addr_valid))
		else $error("ack without address");
	crc_hold_a: assert property (!(xfer_start || addr_valid || byte_valid)
		|=> $stable(check_value)) else $error("checksum moved without byte");
	due_clear_a: assert property (check_byte_due && byte_valid && !addr_valid
		&& !xfer_start |=> !check_byte_due) else $error("check byte still due");
	due_refill_a: assert property ($rose(check_byte_due) |-> !rf)
		else $error("check byte due with refill");
	stop_excl_a: assert property (end_stop |-> !end_reload && !rf)
		else $error("stop with refill");
	rel_need_a: assert property (end_reload |-> rf)
		else $error("reload without refill");
	cover property (addr_ack);
	cover property ($fell(check_byte_due));
	cover property (end_reload);
endmodule
bind smx_top smx_top_chk i_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
	.pready, .pslverr, .xfer_start, .addr_valid, .addr_byte, .byte_valid, .addr_ack,
	.check_byte_due, .check_value, .end_stop, .end_reload);

// ==== verification/smx_bus_model.sv ====
// Far-side party on the two-wire bus: drives SCL.
// SCL pulled up: high when released, 160 ns clock in frames.
`timescale 1ns/1ps
module smx_bus_model (
	// Control
	input  wire logic run,
	input  wire logic hold_low,
	// Bus pin
	output logic      scl
);
	initial
		scl = 1'b1;
	always
	begin
		#80;
		scl <= hold_low ? 1'b0 : (run ? ~scl : 1'b1);
	end
endmodule

// ==== verification/tb_smx_top.sv ====
// Bench for smx_top: APB master, core strobes, SCL party model.
// Assumes smx_consts.svh on the include path.
`timescale 1ns/1ps
`include "smx_consts.svh"
module tb_smx_top;
	typedef struct packed {
		logic [4:0]  c1;
		logic [11:0] c2;
		logic        sl;
		logic [6:0]  ad;
		logic        bad;
		logic        ack;
		logic        due;
		logic        stp;
		logic        rel;
	} smx_row_s;
	logic        pclk, presetn, psel, penable, pwrite, xfer_start, xfer_is_slave;
	logic        addr_valid, byte_valid, run, hold_low, scl_in, pready, pslverr, irq;
	logic        core_enable, addr_ack, check_byte_due, end_stop, end_reload;
	logic [7:0]  paddr, addr_byte, byte_data, check_value;
	logic [31:0] pwdata, prdata, rd;
	int          err_total, total_checks;
	smx_row_s    rows [8] = '{
		'{5'h03, 12'h603, 1'b0, 7'h61, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
		'{5'h11, 12'h603, 1'b0, 7'h61, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
		'{5'h15, 12'h403, 1'b0, 7'h08, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
		'{5'h11, 12'h403, 1'b0, 7'h08, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
		'{5'h19, 12'hC02, 1'b1, 7'h0C, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
		'{5'h11, 12'hC02, 1'b1, 7'h0C, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
		'{5'h1F, 12'h502, 1'b0, 7'h50, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
		'{5'h11, 12'h402, 1'b1, 7'h61, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}
	};
	smx_top i_smx_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .irq, .scl_in, .xfer_start, .xfer_is_slave, .addr_valid,
		.addr_byte, .byte_valid, .byte_data, .core_enable, .addr_ack, .check_byte_due,
		.check_value, .end_stop, .end_reload);
	smx_bus_model i_smx_bus_model (.run, .hold_low, .scl(scl_in));
	initial
	begin
		pclk = 1'b0;
		forever
			#5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d checks %0d", err_total, total_checks);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ({r[6:0], 1'b0} ^ `SMX_CRC_POLY) : {r[6:0], 1'b0};
		return r;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic se);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			err_total++;
			complete_run();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic se;
		apb(1'b1, a, d, se);
	endtask
	task automatic xfer(input smx_row_s r);
		logic [7:0] crc;
		logic       se;
		wr(8'h00, 32'h0);
		wr(8'h00, {27'h0, r.c1 & 5'h1E});
		wr(8'h00, {27'h0, r.c1});
		wr(8'h04, {20'h0, r.c2});
		crc = crc8(8'h00, {r.ad, 1'b0});
		@(posedge pclk);
		xfer_start <= 1'b1;
		xfer_is_slave <= r.sl;
		chk(core_enable, r.c1[0]);
		@(posedge pclk);
		xfer_start <= 1'b0;
		addr_valid <= 1'b1;
		addr_byte <= {r.ad, 1'b0};
		@(posedge pclk);
		addr_valid <= 1'b0;
		#1 chk(addr_ack, r.ack);
		for (int i = 1; i < r.c2[7:0]; i++)
		begin
			@(posedge pclk);
			byte_valid <= 1'b1;
			byte_data <= 8'h11 * i[7:0];
			crc = crc8(crc, 8'h11 * i[7:0]);
		end
		@(posedge pclk);
		byte_valid <= 1'b0;
		#1 chk(check_byte_due, r.due);
		if (r.due)
			chk(check_value, crc);
		@(posedge pclk);
		byte_valid <= 1'b1;
		byte_data <= r.bad ? ~crc : crc;
		@(posedge pclk);
		byte_valid <= 1'b0;
		#1 chk(end_stop, r.stp);
		chk(end_reload, r.rel);
		chk(irq, 1'b0);
		wr(8'h0F, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0C, 32'h0, se);
		chk(rd[3], r.bad & r.due);
		wr(8'h0C, 32'h1F);
	endtask
	initial
	begin
		logic se;
		int k;
		{psel, penable, pwrite, xfer_start, xfer_is_slave, addr_valid, byte_valid} = '0;
		{run, hold_low, paddr, pwdata, addr_byte, byte_data, presetn} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 24; a += 4)
			apb(1'b0, a[7:0], 32'h0, se);
		chk(rd, 32'h0);
		apb(1'b1, 8'h18, 32'hFFFF_FFFF, se);
		chk(se, 1'b1);
		run <= 1'b1;
		foreach (rows[i])
			xfer(rows[i]);
		run <= 1'b0;
		// Low timeout: enable needs both bits, restart on release
		wr(8'h10, 32'h1);
		wr(8'h08, 32'h0FFF_0000);
		wr(8'h08, 32'h0FFF_8000);
		hold_low <= 1'b1;
		repeat (2100) @(posedge pclk);
		chk(irq, 1'b0);
		hold_low <= 1'b0;
		wr(8'h08, 32'h8FFF_8000);
		hold_low <= 1'b1;
		repeat (1000) @(posedge pclk);
		hold_low <= 1'b0;
		repeat (20) @(posedge pclk);
		hold_low <= 1'b1;
		repeat (2000) @(posedge pclk);
		chk(irq, 1'b0);
		for (k = 0; k < 200 && irq !== 1'b1; k++)
			@(negedge pclk);
		chk(irq, 1'b1);
		if (irq !== 1'b1)
			complete_run();
		hold_low <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b0, 8'h0C, 32'h0, se);
		chk(rd[0], 1'b1);
		wr(8'h0C, 32'h1);
		@(negedge pclk);
		chk(irq, 1'b0);
		// Limit and idle frozen while low check on
		wr(8'h08, 32'h0000_1ABC);
		apb(1'b0, 8'h08, 32'h0, se);
		chk(rd, 32'h0);
		wr(8'h08, 32'h0000_1ABC);
		apb(1'b0, 8'h08, 32'h0, se);
		chk(rd, 32'h0000_1ABC);
		complete_run();
	end
endmodule
